// [hdl/flash_device_end.sv]
`timescale 1ns/1ps
module flash_device_end #(
	parameter int ENTRY_CYC = flash_pkg::ENTRY_CYC,
	parameter int EXIT_CYC  = flash_pkg::EXIT_CYC
) (
	input  wire logic        clk,
	input  wire logic        reset,
	flash_link_if.device     link,
	input  wire logic        busy,
	input  wire logic        welSet,
	input  wire logic [7:0]  txByte,
	output logic      [7:0]  opcode,
	output logic             opcodeValid,
	output logic             powerDown,
	output logic             standby,
	output logic             paused,
	output logic             writeEnableLatch,
	output logic             wpLevelN,
	output logic             abortPulse
);
	typedef struct packed {
		flash_pkg::pwr_t              pwr;
		logic [flash_pkg::TIMER_W-1:0] timer;
		logic                          sckPrev;
		logic                          csAct;
		logic [2:0]                    bitCnt;
		logic                          gotByte;
		logic [7:0]                    shift;
		logic [7:0]                    txShift;
		logic [7:0]                    opcode;
		logic                          opcodeValid;
		logic                          paused;
		logic                          write_enable_latch;
		logic                          wpN;
		logic                          abort;
		logic                          so;
		logic                          soOe;
		logic                          standby;
		logic                          powerDown;
	} state_t;

	localparam logic [flash_pkg::TIMER_W-1:0] ENTRY_LOAD =
		flash_pkg::TIMER_W'(ENTRY_CYC - 1);
	localparam logic [flash_pkg::TIMER_W-1:0] EXIT_LOAD =
		flash_pkg::TIMER_W'(EXIT_CYC - 1);

	state_t q;
	state_t d;

	logic [4:0] pinsSync;
	logic       csNS;
	logic       sckS;
	logic       holdNS;
	logic       siS;
	logic       wpNS;

	// all link pins cross through two flops before use
	sync2 #(
		.W(5),
		.RST_VAL(flash_pkg::PINS_IDLE)
	) pinSync (
		.clk   (clk),
		.reset (reset),
		.in    ({link.csN, link.sck, link.holdN, link.si, link.wpN}),
		.out   (pinsSync)
	);

	assign {csNS, sckS, holdNS, siS, wpNS} = pinsSync;

	logic csAct;
	logic sckRise;
	logic sckFall;
	logic frameEnd;
	logic wholeOpcode;
	logic [7:0] newByte;

	always_comb
	begin
		csAct = !csNS;
		sckRise = sckS && !q.sckPrev;
		sckFall = !sckS && q.sckPrev;
		frameEnd = !csAct && q.csAct;
		wholeOpcode = q.gotByte && (q.bitCnt == flash_pkg::BIT_FIRST);
		newByte = {q.shift[6:0], siS};

		d = q;
		d.sckPrev = sckS;
		d.csAct = csAct;
		d.abort = 1'b0;
		d.opcodeValid = 1'b0;
		d.wpN = wpNS;

		// pause level only moves during a low clock phase, and clears on deselect
		if (!csAct)
			d.paused = 1'b0;
		else if (!sckS)
			d.paused = !holdNS;

		if (csAct && !q.paused)
		begin
			if (sckRise)
			begin
				d.shift = newByte;
				d.bitCnt = q.bitCnt + 3'h1;
				if (q.bitCnt == flash_pkg::BIT_LAST && !q.gotByte)
				begin
					d.gotByte = 1'b1;
					d.opcode = newByte;
					// while powered down every opcode but resume is dropped
					d.opcodeValid = (q.pwr == flash_pkg::PWR_STANDBY)
						|| (q.pwr == flash_pkg::PWR_DOWN
						&& newByte == flash_pkg::OP_RESUME);
				end
			end
			if (sckFall)
			begin
				if (q.bitCnt == flash_pkg::BIT_FIRST)
				begin
					d.so = txByte[7];
					d.txShift = {txByte[6:0], 1'b0};
				end
				else
				begin
					d.so = q.txShift[7];
					d.txShift = {q.txShift[6:0], 1'b0};
				end
			end
		end

		// power state timers; busy is never gated by pause
		unique case (q.pwr)
			flash_pkg::PWR_STANDBY:
			begin
			end
			flash_pkg::PWR_ENTERING:
			begin
				if (q.timer == '0)
					d.pwr = flash_pkg::PWR_DOWN;
				else
					d.timer = q.timer - 1'b1;
			end
			flash_pkg::PWR_DOWN:
			begin
			end
			flash_pkg::PWR_EXITING:
			begin
				if (q.timer == '0)
					d.pwr = flash_pkg::PWR_STANDBY;
				else
					d.timer = q.timer - 1'b1;
			end
		endcase

		if (frameEnd)
		begin
			d.bitCnt = flash_pkg::BIT_FIRST;
			d.gotByte = 1'b0;
			if (q.paused || !holdNS)
			begin
				d.abort = 1'b1;
				d.write_enable_latch = 1'b0;
			end
			else if (wholeOpcode)
			begin
				if (q.pwr == flash_pkg::PWR_STANDBY
					&& q.opcode == flash_pkg::OP_POWER_DOWN && !busy)
				begin
					d.pwr = flash_pkg::PWR_ENTERING;
					d.timer = ENTRY_LOAD;
				end
				else if (q.pwr == flash_pkg::PWR_DOWN
					&& q.opcode == flash_pkg::OP_RESUME)
				begin
					d.pwr = flash_pkg::PWR_EXITING;
					d.timer = EXIT_LOAD;
				end
			end
		end

		// a set arriving with the abort clear wins when the next power state is standby
		if (welSet && d.pwr == flash_pkg::PWR_STANDBY)
			d.write_enable_latch = 1'b1;

		d.soOe = csAct && !d.paused && (q.pwr == flash_pkg::PWR_STANDBY);
		d.standby = !csAct && !busy && (d.pwr == flash_pkg::PWR_STANDBY);
		d.powerDown = (d.pwr == flash_pkg::PWR_DOWN);
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			q <= '0;
			q.pwr <= flash_pkg::PWR_STANDBY;
			q.wpN <= 1'b1;
		end
		else
			q <= d;
	end

	assign link.so = q.so;
	assign link.soOe = q.soOe;
	assign opcode = q.opcode;
	assign opcodeValid = q.opcodeValid;
	assign powerDown = q.powerDown;
	assign standby = q.standby;
	assign paused = q.paused;
	assign writeEnableLatch = q.write_enable_latch;
	assign wpLevelN = q.wpN;
	assign abortPulse = q.abort;
endmodule

// [hdl/flash_pkg.sv]
package flash_pkg;
	localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
	localparam logic [7:0] OP_RESUME     = 8'hab;
	localparam int BYTE_BITS             = 8;
	localparam logic [2:0] BIT_LAST      = 3'h7;
	localparam logic [2:0] BIT_FIRST     = 3'h0;
	localparam int CLK_NS                = 25;
	// entry and exit limits are plain defaults, longest times round down
	localparam int POWER_DOWN_ENTRY_TIME_NS = 1000;
	localparam int POWER_DOWN_EXIT_TIME_NS  = 3000;
	localparam int ENTRY_CYC = (POWER_DOWN_ENTRY_TIME_NS / CLK_NS < 1) ? 1
		: POWER_DOWN_ENTRY_TIME_NS / CLK_NS;
	localparam int EXIT_CYC  = (POWER_DOWN_EXIT_TIME_NS / CLK_NS < 1) ? 1
		: POWER_DOWN_EXIT_TIME_NS / CLK_NS;
	localparam int TIMER_W   = 12;
	// host serial clock: 8 system cycles per period, 200 ns at 40 MHz
	localparam int SCK_HALF_CYC = 4;
	localparam int DIV_W        = 8;
	localparam int NBITS_W      = 5;
	// idle pin levels {csN, sck, holdN, si, wpN} and the pulled-up output line
	localparam logic [4:0] PINS_IDLE = 5'h15;
	localparam logic       SO_IDLE   = 1'h1;

	typedef enum logic [1:0] {
		PWR_STANDBY  = 2'b00,
		PWR_ENTERING = 2'b01,
		PWR_DOWN     = 2'b10,
		PWR_EXITING  = 2'b11
	} pwr_t;

	typedef enum logic [1:0] {
		HST_IDLE  = 2'b00,
		HST_SHIFT = 2'b01,
		HST_END   = 2'b10
	} hst_t;
endpackage

// [hdl/flash_link_if.sv]
`timescale 1ns/1ps
interface flash_link_if;
	logic csN;
	logic sck;
	logic holdN;
	logic si;
	logic wpN;
	logic so;
	logic soOe;
	logic soLine;

	// modelled pull-up on the serial output line when the device lets go
	assign soLine = soOe ? so : 1'b1;

	modport device (
		input  csN,
		input  sck,
		input  holdN,
		input  si,
		input  wpN,
		output so,
		output soOe
	);

	modport host (
		output csN,
		output sck,
		output holdN,
		output si,
		output wpN,
		input  soLine
	);
endinterface

// [hdl/sync2.sv]
`timescale 1ns/1ps
module sync2 #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] in,
	output logic      [W-1:0] out
);
	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} state_t;

	state_t q;
	state_t d;

	always_comb
	begin
		d = q;
		d.first = in;
		d.second = q.first;
	end

	always_ff @(posedge clk)
	begin
		// reset to the line's idle level so no false select or edge follows reset
		if (reset)
		begin
			q.first <= RST_VAL;
			q.second <= RST_VAL;
		end
		else
			q <= d;
	end

	assign out = q.second;
endmodule

// [hdl/flash_host_end.sv]
`timescale 1ns/1ps
module flash_host_end #(
	parameter int HALF_CYC = flash_pkg::SCK_HALF_CYC
) (
	input  wire logic                          clk,
	input  wire logic                          reset,
	flash_link_if.host                         link,
	input  wire logic                          start,
	input  wire logic [7:0]                    txOpcode,
	input  wire logic [flash_pkg::NBITS_W-1:0] nBits,
	input  wire logic                          pauseReq,
	input  wire logic                          abortReq,
	input  wire logic                          wpReq,
	output logic                               busy,
	output logic                               done,
	output logic      [7:0]                    rxByte
);
	typedef struct packed {
		flash_pkg::hst_t               st;
		logic [flash_pkg::DIV_W-1:0]   divCnt;
		logic                          sck;
		logic                          csN;
		logic                          holdN;
		logic                          si;
		logic                          wpN;
		logic                          pend;
		logic [flash_pkg::NBITS_W-1:0] bitsLeft;
		logic [7:0]                    shift;
		logic [7:0]                    rx;
		logic                          busy;
		logic                          done;
	} state_t;

	localparam logic [flash_pkg::DIV_W-1:0] DIV_LAST =
		flash_pkg::DIV_W'(HALF_CYC - 1);

	state_t q;
	state_t d;
	logic   soS;
	logic   tick;

	sync2 #(
		.W(1),
		.RST_VAL(flash_pkg::SO_IDLE)
	) soSync (
		.clk   (clk),
		.reset (reset),
		.in    (link.soLine),
		.out   (soS)
	);

	always_comb
	begin
		tick = (q.divCnt == DIV_LAST);
		d = q;
		d.done = 1'b0;
		d.pend = 1'b0;
		d.wpN = !wpReq;
		d.divCnt = tick ? '0 : q.divCnt + 1'b1;

		// next bit goes out one cycle after the rising edge, a full period ahead
		if (q.pend)
		begin
			d.si = q.shift[7];
			d.shift = {q.shift[6:0], 1'b0};
		end

		unique case (q.st)
			flash_pkg::HST_IDLE:
			begin
				d.divCnt = '0;
				d.sck = 1'b0;
				d.csN = 1'b1;
				d.holdN = 1'b1;
				if (start && nBits != '0)
				begin
					d.st = flash_pkg::HST_SHIFT;
					d.csN = 1'b0;
					d.busy = 1'b1;
					d.si = txOpcode[7];
					d.shift = {txOpcode[6:0], 1'b0};
					d.bitsLeft = nBits;
				end
			end
			flash_pkg::HST_SHIFT:
			begin
				if (tick)
				begin
					d.sck = !q.sck;
					if (!q.sck && q.holdN && q.bitsLeft != '0)
					begin
						d.bitsLeft = q.bitsLeft - 1'b1;
						d.pend = 1'b1;
					end
					if (q.sck)
					begin
						d.rx = {q.rx[6:0], soS};
						// hold pin only moves on the same clock as a falling edge
						d.holdN = !pauseReq;
						if (q.bitsLeft == '0 && !pauseReq)
							d.st = flash_pkg::HST_END;
					end
				end
			end
			flash_pkg::HST_END:
			begin
				if (tick)
				begin
					d.st = flash_pkg::HST_IDLE;
					d.csN = 1'b1;
					d.busy = 1'b0;
					d.done = 1'b1;
				end
			end
			default:
			begin
				d.st = flash_pkg::HST_IDLE;
			end
		endcase

		// deselect at once; hold pin left as is so a paused abort is seen
		if (abortReq && q.st != flash_pkg::HST_IDLE)
		begin
			d.st = flash_pkg::HST_IDLE;
			d.csN = 1'b1;
			d.sck = 1'b0;
			d.holdN = q.holdN;
			d.busy = 1'b0;
			d.done = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			q <= '0;
			q.st <= flash_pkg::HST_IDLE;
			q.csN <= 1'b1;
			q.holdN <= 1'b1;
			q.wpN <= 1'b1;
		end
		else
			q <= d;
	end

	assign link.csN = q.csN;
	assign link.sck = q.sck;
	assign link.holdN = q.holdN;
	assign link.si = q.si;
	assign link.wpN = q.wpN;
	assign busy = q.busy;
	assign done = q.done;
	assign rxByte = q.rx;
endmodule

// [bench/flash_link_chk.sv]
`timescale 1ns/1ps
module flash_link_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic csN,
	input wire logic sck,
	input wire logic holdN,
	input wire logic si,
	input wire logic wpN,
	input wire logic so,
	input wire logic soOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_held;
		(!holdN && !csN)[*8];
	endsequence
	sequence s_half;
		sck[*4] ##1 !sck;
	endsequence

	property p_hold_off;
		s_held |-> !soOe;
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("output driven in pause");
	property p_desel;
		$rose(csN) |-> ##[1:5] !soOe;
	endproperty
	a_desel: assert property (p_desel) else $error("output kept after deselect");
	property p_launch;
		$changed(so) && $past(soOe) && soOe |-> !$past(sck, 3) && $past(sck, 4);
	endproperty
	a_launch: assert property (p_launch) else $error("output moved off falling edge");
	property p_si_rise;
		$changed(si) && !csN && !$past(csN) |-> $past(sck) && !$past(sck, 2);
	endproperty
	a_si_rise: assert property (p_si_rise) else $error("input bit moved off rise");
	property p_lead;
		$fell(csN) |-> !sck[*3];
	endproperty
	a_lead: assert property (p_lead) else $error("clock too soon after select");
	property p_half;
		$rose(sck) |-> s_half;
	endproperty
	a_half: assert property (p_half) else $error("clock high phase length");
	property p_hold_edge;
		$changed(holdN) && !csN && !$past(csN) |-> $fell(sck);
	endproperty
	a_hold_edge: assert property (p_hold_edge) else $error("pause pin moved off low phase");
	property p_gap;
		$rose(csN) |-> csN[*2];
	endproperty
	a_gap: assert property (p_gap) else $error("frames too close");
endmodule

// [bench/tb_flash_power_down_hold_ctrl.sv]
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin error_cnt++; $display("wrong value %s exp %0h got %0h", n, e, a); end end
module tb_flash_power_down_hold_ctrl;
	localparam int EW = flash_pkg::ENTRY_CYC + 8;
	localparam int XW = flash_pkg::EXIT_CYC + 8;
	logic       clk, reset, start, pauseReq, abortReq, wpReq, busyIn, welSet;
	logic       sawAbort = 1'b0;
	logic       hBusy, done, opValid, powerDown, standby, paused, write_enable_latch, wpLevelN, abortPulse;
	logic [7:0] txOpcode, txByte, rxByte, opcode, rop;
	logic [4:0] nBits, nb;
	logic [4:0] bad [3] = '{5'h05, 5'h09, 5'h0f};
	int         error_cnt, tests_run, seed, k;
	int         v0, d0;
	int         validCnt = 0;
	int         doneCnt = 0;

	flash_link_if link ();
	flash_device_end flash_device_end_inst (.clk(clk), .reset(reset), .link(link),
		.busy(busyIn), .welSet(welSet), .txByte(txByte), .opcode(opcode),
		.opcodeValid(opValid), .powerDown(powerDown), .standby(standby), .paused(paused),
		.writeEnableLatch(write_enable_latch), .wpLevelN(wpLevelN), .abortPulse(abortPulse));
	flash_host_end flash_host_end_inst (.clk(clk), .reset(reset), .link(link), .start(start),
		.txOpcode(txOpcode), .nBits(nBits), .pauseReq(pauseReq), .abortReq(abortReq),
		.wpReq(wpReq), .busy(hBusy), .done(done), .rxByte(rxByte));
	flash_link_chk flash_link_chk_inst (.clk(clk), .reset(reset), .csN(link.csN),
		.sck(link.sck), .holdN(link.holdN), .si(link.si), .wpN(link.wpN), .so(link.so),
		.soOe(link.soOe));

	always #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		if (abortPulse === 1'b1)
			sawAbort <= 1'b1;
		if (opValid === 1'b1)
			validCnt <= validCnt + 1;
		if (done === 1'b1)
			doneCnt <= doneCnt + 1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic frame(input logic [7:0] o, input logic [4:0] n);
		d0 = doneCnt;
		@(posedge clk);
		txOpcode <= o;
		nBits <= n;
		start <= 1'b1;
		tick(1);
		start <= 1'b0;
		tick(1);
		for (k = 0; k < 3000 && hBusy !== 1'b0; k++) @(posedge clk);
		// counter is bumped by the edge that ends the loop, so look half a cycle on
		@(negedge clk);
		`CHK("done", d0 + 1, doneCnt)
	endtask

	// a first byte is recognised when complete; in power-down only resume counts
	function automatic int expValid(input logic down, input logic [7:0] op,
		input logic [4:0] n);
		return (n >= 5'h08 && (!down || op == flash_pkg::OP_RESUME)) ? 1 : 0;
	endfunction

	// random opcode that is neither power-down nor resume
	task automatic pick;
		rop = 8'($random(seed));
		if (rop == flash_pkg::OP_POWER_DOWN || rop == flash_pkg::OP_RESUME)
			rop = rop ^ 8'h01;
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		#1000000;
		error_cnt++;
		print_verdict;
	end

	initial
	begin
		{clk, start, pauseReq, abortReq, wpReq, busyIn, welSet} = '0;
		{txOpcode, txByte, nBits, error_cnt, tests_run} = '0;
		reset = 1'b1;
		seed = 32'ha44788a4;
		tick(12);
		reset <= 1'b0;
		tick(8);
		@(negedge clk);
		`CHK("standby", 1'b1, standby)
		`CHK("powerDown", 1'b0, powerDown)
		repeat (6)
		begin
			@(posedge clk);
			txByte <= 8'($random(seed));
			pick;
			v0 = validCnt;
			frame(rop, 5'h10);
			@(negedge clk);
			`CHK("rxByte", txByte, rxByte)
			`CHK("opcode", rop, opcode)
			`CHK("powerDown", 1'b0, powerDown)
			`CHK("opcodeValid", v0 + expValid(1'b0, rop, 5'h10), validCnt)
		end
		foreach (bad[i])
		begin
			frame(flash_pkg::OP_POWER_DOWN, bad[i]);
			tick(EW);
			`CHK("standby", 1'b1, standby)
		end
		busyIn <= 1'b1;
		frame(flash_pkg::OP_POWER_DOWN, 5'h08);
		tick(EW);
		`CHK("standby", 1'b0, standby)
		`CHK("powerDown", 1'b0, powerDown)
		busyIn <= 1'b0;
		frame(flash_pkg::OP_POWER_DOWN, 5'h10);
		tick(EW);
		`CHK("powerDown", 1'b1, powerDown)
		for (int i = 0; i < 5; i++)
		begin
			pick;
			if (i > 2)
				rop = flash_pkg::OP_RESUME;
			nb = (i == 3) ? 5'h07 : (i == 4) ? 5'h0c : 5'h08;
			v0 = validCnt;
			frame(rop, nb);
			tick(XW);
			`CHK("powerDown", 1'b1, powerDown)
			`CHK("opcodeValid", v0 + expValid(1'b1, rop, nb), validCnt)
		end
		frame(flash_pkg::OP_RESUME, 5'h08);
		tick(XW);
		`CHK("standby", 1'b1, standby)
		pick;
		fork
			frame(rop, 5'h08);
			begin
				tick(20);
				pauseReq <= 1'b1;
				tick(30);
				wpReq <= 1'b1;
				tick(8);
				@(negedge clk);
				`CHK("paused", 1'b1, paused)
				`CHK("soLine", 1'b1, link.soLine)
				`CHK("wpLevelN", 1'b0, wpLevelN)
				@(posedge clk);
				pauseReq <= 1'b0;
				wpReq <= 1'b0;
			end
		join
		@(negedge clk);
		`CHK("paused", 1'b0, paused)
		`CHK("opcode", rop, opcode)
		@(posedge clk);
		welSet <= 1'b1;
		tick(1);
		welSet <= 1'b0;
		tick(2);
		`CHK("wel", 1'b1, write_enable_latch)
		`CHK("abortPulse", 1'b0, sawAbort)
		fork
			frame(rop, 5'h10);
			begin
				tick(20);
				pauseReq <= 1'b1;
				// abort lands in a low clock phase so no high phase is cut short
				tick(16);
				abortReq <= 1'b1;
				tick(1);
				abortReq <= 1'b0;
			end
		join
		pauseReq <= 1'b0;
		tick(6);
		`CHK("abortPulse", 1'b1, sawAbort)
		`CHK("wel", 1'b0, write_enable_latch)
		print_verdict;
	end
endmodule
